// ==== rxdl_axil.v ====
/*
  AXI4-Lite slave holding the receive and transmit list bases, mode and readback registers.
  Assumes a master with at most one write and one read outstanding.
*/
`include "rxdl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rxdl_axil (
   input wire aclk,
   input wire aresetn,
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] status_in,
   input wire [31:0] cur_desc_in,
   output reg [31:0] rx_base_r,
   output reg [31:0] tx_base_r,
   output reg [31:0] mode_r
);

   reg aw_have_r;
   reg w_have_r;
   reg [5:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   wire [31:0] wmask;
   wire aw_take;
   wire w_take;
   wire ar_take;

   assign aw_take = s_axi_awready & s_axi_awvalid;
   assign w_take = s_axi_wready & s_axi_wvalid;
   assign ar_take = s_axi_arready & s_axi_arvalid;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : lane
         assign wmask[8*g+7:8*g] = {8{w_strb_r[g]}};
      end
   endgenerate

   // ----------------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RXDL_RESP_OKAY;
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 6'h00;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         rx_base_r <= `RXDL_RST_BASE;
         tx_base_r <= `RXDL_RST_BASE;
         mode_r <= `RXDL_RST_MODE;
      end else begin
         s_axi_awready <= ~(aw_have_r | aw_take);
         s_axi_wready <= ~(w_have_r | w_take);
         if (aw_take) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (w_take) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (aw_have_r && w_have_r && !s_axi_bvalid) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `RXDL_RESP_OKAY;
            // each list has its own base register
            if (aw_addr_r == `RXDL_OFS_RX_BASE) begin
               rx_base_r <= (rx_base_r & ~wmask) | (w_data_r & wmask);
            end else if (aw_addr_r == `RXDL_OFS_TX_BASE) begin
               tx_base_r <= (tx_base_r & ~wmask) | (w_data_r & wmask);
            end else if (aw_addr_r == `RXDL_OFS_MODE) begin
               mode_r <= (mode_r & ~wmask) | (w_data_r & wmask);
            end else if (aw_addr_r == `RXDL_OFS_STATUS || aw_addr_r == `RXDL_OFS_CUR_DESC) begin
               // read-only: write accepted and dropped
               s_axi_bresp <= `RXDL_RESP_OKAY;
            end else begin
               s_axi_bresp <= `RXDL_RESP_SLVERR;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RXDL_RESP_OKAY;
      end else begin
         s_axi_arready <= ~ar_take & ~s_axi_rvalid;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RXDL_RESP_OKAY;
            // base low bits read zero: lists sit on longword boundaries
            if (s_axi_araddr == `RXDL_OFS_RX_BASE) begin
               s_axi_rdata <= {rx_base_r[31:2], 2'h0};
            end else if (s_axi_araddr == `RXDL_OFS_TX_BASE) begin
               s_axi_rdata <= {tx_base_r[31:2], 2'h0};
            end else if (s_axi_araddr == `RXDL_OFS_MODE) begin
               s_axi_rdata <= mode_r;
            end else if (s_axi_araddr == `RXDL_OFS_STATUS) begin
               s_axi_rdata <= status_in;
            end else if (s_axi_araddr == `RXDL_OFS_CUR_DESC) begin
               s_axi_rdata <= cur_desc_in;
            end else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RXDL_RESP_SLVERR;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ==== rxdl_defs.vh ====
/*
  Constants of the receive descriptor-list engine: register offsets,
  reset values, descriptor word layouts and bus codes.
  Assumes it is included by its bare name from each design file.
*/
`ifndef RXDL_DEFS_VH
`define RXDL_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses on the AXI4-Lite slave)
// ----------------------------------------------------------------------
`define RXDL_OFS_RX_BASE 6'h00
`define RXDL_OFS_TX_BASE 6'h04
`define RXDL_OFS_MODE 6'h08
`define RXDL_OFS_STATUS 6'h0C
`define RXDL_OFS_CUR_DESC 6'h10

// ----------------------------------------------------------------------
// reset values and operating mode fields
// ----------------------------------------------------------------------
`define RXDL_RST_BASE 32'h00000000
`define RXDL_RST_MODE 32'h00000001
`define RXDL_MODE_CHAIN_EN 0
`define RXDL_MODE_START 1
`define RXDL_MODE_RX_ALL 30

// ----------------------------------------------------------------------
// receive descriptor status word fields
// ----------------------------------------------------------------------
`define RXDL_ST_OWN 31
`define RXDL_ST_FF 30
`define RXDL_ST_FL_HI 29
`define RXDL_ST_FL_LO 16
`define RXDL_ST_ES 15
`define RXDL_ST_DE 14
`define RXDL_ST_RF 11
`define RXDL_ST_FS 9
`define RXDL_ST_LS 8
`define RXDL_ST_CS 6
`define RXDL_ST_CE 1

// ----------------------------------------------------------------------
// receive descriptor control word fields and list geometry
// ----------------------------------------------------------------------
`define RXDL_CT_B1_HI 10
`define RXDL_CT_B1_LO 0
`define RXDL_CT_B2_HI 21
`define RXDL_CT_B2_LO 11
`define RXDL_CT_CHAIN 24
`define RXDL_CT_EOR 25
`define RXDL_DESC_STRIDE 32'h00000010
`define RXDL_WORD_BYTES 11'h004

// ----------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------
`define RXDL_RESP_OKAY 2'h0
`define RXDL_RESP_SLVERR 2'h2

`endif

// ==== rxdl_engine.v ====
/*
  Receive descriptor-list engine: walks the receive list in host memory,
  writes frame words into buffers and writes back the status word.
  Assumes a single-clock memory port (req held until a one-cycle ack) and
  a same-clock receive word stream with end-of-frame status beside it.
*/
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`include "rxdl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rxdl_engine (
   input wire aclk,
   input wire aresetn,
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   output reg mem_req_r,
   output reg mem_we_r,
   output reg [31:0] mem_addr_r,
   output reg [31:0] mem_wdata_r,
   input wire [31:0] mem_rdata,
   input wire mem_ack,
   input wire rx_valid,
   output reg rx_ready_r,
   input wire [31:0] rx_data,
   input wire rx_last,
   input wire [1:0] rx_last_bytes,
   input wire rx_crc_err,
   input wire rx_phy_err,
   input wire rx_collision,
   input wire rx_runt,
   input wire rx_addr_fail,
   output wire [31:0] tx_list_base
);

   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_RD = 3'h1;
   localparam [2:0] S_DATA = 3'h2;
   localparam [2:0] S_PEEK = 3'h3;
   localparam [2:0] S_DROP = 3'h4;
   localparam [2:0] S_WB = 3'h5;
   localparam [2:0] S_NEXT = 3'h6;

   wire [31:0] rx_base;
   wire [31:0] mode;
   wire [31:0] status_word;
   reg [2:0] state_r;
   reg [31:0] cur_r;
   reg [31:0] ctrl_r;
   reg [31:0] a1_r;
   reg [31:0] a2_r;
   reg [1:0] rd_idx_r;
   reg buf_sel_r;
   reg [31:0] buf_addr_r;
   reg [10:0] buf_left_r;
   reg [13:0] len_r;
   reg first_r;
   reg ls_r;
   reg de_r;
   reg crc_r;
   reg phy_r;
   reg col_r;
   reg runt_r;
   reg fail_r;
   reg [31:0] next_desc_nxt;
   wire take;
   wire chained;
   wire chain_en;
   wire room;
   wire [10:0] b2_size;
   wire [2:0] word_bytes;

   assign take = rx_valid & rx_ready_r;
   assign chained = ctrl_r[`RXDL_CT_CHAIN];
   assign chain_en = mode[`RXDL_MODE_CHAIN_EN];
   assign room = (buf_left_r >= `RXDL_WORD_BYTES);
   assign b2_size = ctrl_r[`RXDL_CT_B2_HI:`RXDL_CT_B2_LO];
   // a last word carries 1..4 bytes, 0 on the stream meaning a full word
   assign word_bytes = (rx_last && rx_last_bytes != 2'h0) ? {1'b0, rx_last_bytes} : 3'h4;

   // ----------------------------------------------------------------------
   // register slave and status word
   // ----------------------------------------------------------------------
   rxdl_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .status_in({29'h00000000, state_r}),
      .cur_desc_in(cur_r),
      .rx_base_r(rx_base),
      .tx_base_r(tx_list_base),
      .mode_r(mode)
   );

   rxdl_status u_status (
      .last_seg(ls_r),
      .first_seg(first_r),
      .desc_err(de_r),
      .crc_err(crc_r),
      .phy_err(phy_r),
      .collision(col_r),
      .runt(runt_r),
      .addr_fail(fail_r),
      .rx_all(mode[`RXDL_MODE_RX_ALL]),
      .frame_len(len_r),
      .status_word(status_word)
   );

   // ----------------------------------------------------------------------
   // next descriptor address
   // ----------------------------------------------------------------------
   always @* begin
      next_desc_nxt = cur_r + `RXDL_DESC_STRIDE;
      if (chained) begin
         next_desc_nxt = a2_r;
      end else if (ctrl_r[`RXDL_CT_EOR]) begin
         next_desc_nxt = rx_base;
      end
   end

   // ----------------------------------------------------------------------
   // list walker
   // ----------------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= S_IDLE;
         cur_r <= 32'h00000000;
         ctrl_r <= 32'h00000000;
         a1_r <= 32'h00000000;
         a2_r <= 32'h00000000;
         rd_idx_r <= 2'h0;
         buf_sel_r <= 1'b0;
         buf_addr_r <= 32'h00000000;
         buf_left_r <= 11'h000;
         len_r <= 14'h0000;
         first_r <= 1'b0;
         ls_r <= 1'b0;
         de_r <= 1'b0;
         crc_r <= 1'b0;
         phy_r <= 1'b0;
         col_r <= 1'b0;
         runt_r <= 1'b0;
         fail_r <= 1'b0;
         mem_req_r <= 1'b0;
         mem_we_r <= 1'b0;
         mem_addr_r <= 32'h00000000;
         mem_wdata_r <= 32'h00000000;
         rx_ready_r <= 1'b0;
      end else begin
         if (take) begin
            rx_ready_r <= 1'b0;
            len_r <= len_r + {11'h000, word_bytes};
            if (rx_last) begin
               crc_r <= rx_crc_err;
               phy_r <= rx_phy_err;
               col_r <= rx_collision;
               runt_r <= rx_runt;
               fail_r <= rx_addr_fail;
            end
         end
         case (state_r)
            S_IDLE: begin
               if (!mode[`RXDL_MODE_START]) begin
                  cur_r <= {rx_base[31:2], 2'h0};
               end else if (rx_valid) begin
                  // a frame always opens a fresh descriptor
                  state_r <= S_RD;
                  rd_idx_r <= 2'h0;
                  first_r <= 1'b1;
                  ls_r <= 1'b0;
                  de_r <= 1'b0;
                  len_r <= 14'h0000;
               end
            end
            S_RD: begin
               if (!mem_req_r) begin
                  mem_req_r <= 1'b1;
                  mem_we_r <= 1'b0;
                  mem_addr_r <= cur_r + {28'h0000000, rd_idx_r, 2'h0};
               end else if (mem_ack) begin
                  mem_req_r <= 1'b0;
                  rd_idx_r <= rd_idx_r + 2'h1;
                  if (rd_idx_r == 2'h0) begin
                     // host-owned at frame start: back off and poll again
                     if (!mem_rdata[`RXDL_ST_OWN]) begin
                        state_r <= S_IDLE;
                     end
                  end else if (rd_idx_r == 2'h1) begin
                     ctrl_r <= mem_rdata;
                  end else if (rd_idx_r == 2'h2) begin
                     a1_r <= mem_rdata;
                  end else begin
                     a2_r <= mem_rdata;
                     buf_sel_r <= 1'b0;
                     buf_addr_r <= a1_r;
                     buf_left_r <= ctrl_r[`RXDL_CT_B1_HI:`RXDL_CT_B1_LO];
                     state_r <= S_DATA;
                  end
               end
            end
            S_DATA: begin
               if (take) begin
                  buf_addr_r <= buf_addr_r + 32'h00000004;
                  buf_left_r <= buf_left_r - `RXDL_WORD_BYTES;
                  if (rx_last) begin
                     ls_r <= 1'b1;
                     state_r <= S_WB;
                  end
               end else if (mem_req_r) begin
                  if (mem_ack) begin
                     mem_req_r <= 1'b0;
                     rx_ready_r <= 1'b1;
                  end
               end else if (!rx_ready_r) begin
                  if (room && rx_valid) begin
                     // payload only; status never lands in a buffer
                     mem_req_r <= 1'b1;
                     mem_we_r <= 1'b1;
                     mem_addr_r <= buf_addr_r;
                     mem_wdata_r <= rx_data;
                  end else if (!room) begin
                     if (!buf_sel_r && !chained && b2_size >= `RXDL_WORD_BYTES) begin
                        buf_sel_r <= 1'b1;
                        buf_addr_r <= a2_r;
                        buf_left_r <= b2_size;
                     end else if (chain_en) begin
                        state_r <= S_PEEK;
                     end else begin
                        // spanning switched off: cut the frame here
                        de_r <= 1'b1;
                        rx_ready_r <= 1'b1;
                        state_r <= S_DROP;
                     end
                  end
               end
            end
            S_PEEK: begin
               if (!mem_req_r) begin
                  mem_req_r <= 1'b1;
                  mem_we_r <= 1'b0;
                  mem_addr_r <= next_desc_nxt;
               end else if (mem_ack) begin
                  mem_req_r <= 1'b0;
                  if (mem_rdata[`RXDL_ST_OWN]) begin
                     state_r <= S_WB;
                  end else begin
                     de_r <= 1'b1;
                     rx_ready_r <= 1'b1;
                     state_r <= S_DROP;
                  end
               end
            end
            S_DROP: begin
               // truncated tail is swallowed, never written anywhere
               if (take && rx_last) begin
                  ls_r <= 1'b1;
                  state_r <= S_WB;
               end else begin
                  rx_ready_r <= 1'b1;
               end
            end
            S_WB: begin
               if (!mem_req_r) begin
                  // one write carries status, length (closing descriptor only) and cleared ownership
                  mem_req_r <= 1'b1;
                  mem_we_r <= 1'b1;
                  mem_addr_r <= cur_r;
                  mem_wdata_r <= status_word;
               end else if (mem_ack) begin
                  mem_req_r <= 1'b0;
                  state_r <= S_NEXT;
               end
            end
            S_NEXT: begin
               cur_r <= next_desc_nxt;
               first_r <= 1'b0;
               rd_idx_r <= 2'h0;
               if (ls_r) begin
                  state_r <= S_IDLE;
               end else begin
                  state_r <= S_RD;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ==== rxdl_engine_assertions.sv ====
/* port checker for rxdl_engine, bound onto it after the module.
   assumes one clock and the synchronous active-low reset */
`timescale 1ns/1ps
`default_nettype none
module rxdl_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic mem_req_r,
   input wire logic mem_we_r,
   input wire logic [31:0] mem_addr_r,
   input wire logic mem_ack,
   input wire logic rx_valid,
   input wire logic rx_ready_r
);
   // ------------------------------------------------------------
   // port timing
   // ------------------------------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("write answer withdrawn");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rd");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
   mem_hold_a: assert property (mem_req_r && !mem_ack |=> mem_req_r && $stable({mem_we_r, mem_addr_r})) else $error("m");
   mem_drop_a: assert property (mem_ack && mem_req_r |=> !mem_req_r) else $error("memory request kept after ack");
   word_align_a: assert property (mem_req_r |-> mem_addr_r[1:0] == 2'h0) else $error("address not aligned");
   take_after_write_a: assert property (rx_ready_r |-> !mem_req_r) else $error("word taken while memory busy");
   frame_take_c: cover property (rx_valid && rx_ready_r);
   mem_write_c: cover property (mem_req_r && mem_we_r && mem_ack);
   resp_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind rxdl_engine rxdl_chk rxdl_chk_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_ack, .rx_valid, .rx_ready_r);
`default_nettype wire

// ==== rxdl_engine_tb.sv ====
/* self-checking bench for rxdl_engine with its host memory model.
   assumes the design, the memory model and the checker compile first */
`timescale 1ns/1ps
`default_nettype none
module rxdl_engine_tb;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, rx_valid = 1'b0, rx_last = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, rx_data = 32'h0;
   logic [1:0] rx_last_bytes = 2'h0;
   logic [4:0] rx_flags = 5'h00;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req_r, mem_we_r, mem_ack, rx_ready_r;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, mem_addr_r, mem_wdata_r, mem_rdata, tx_list_base;
   logic [31:0] q[$];
   int errors = 0, n_checks = 0, cur = 0;
   always #10 aclk = ~aclk;
   rxdl_engine rxdl_engine_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req_r,
      .mem_we_r, .mem_addr_r, .mem_wdata_r, .mem_rdata, .mem_ack, .rx_valid, .rx_ready_r, .rx_data, .rx_last,
      .rx_last_bytes, .rx_crc_err(rx_flags[4]), .rx_phy_err(rx_flags[3]), .rx_collision(rx_flags[2]),
      .rx_runt(rx_flags[1]), .rx_addr_fail(rx_flags[0]), .tx_list_base);
   rxdl_mem_model rxdl_mem_model_i (.aclk, .mem_req_r, .mem_we_r, .mem_addr_r, .mem_wdata_r, .slow, .mem_ack,
      .mem_rdata);
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got);
      logic [31:0] e;
      e = q.size() ? q.pop_front() : ~got;
      n_checks++;
      if (got !== e) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, e);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic tick(inout int k);
      @(posedge aclk);
      k++;
      if (k >= 3000) begin
         errors++;
         $display("mismatch at %0t: wait timed out", $time);
         end_of_test;
      end
   endtask
   task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
      int k;
      k = 0;
      q.push_back({30'h0, r});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         tick(k);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
   endtask
   task automatic axr(input logic [5:0] a, input logic [31:0] e);
      int k;
      k = 0;
      q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         tick(k);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
   endtask
   // a frame waits until every noted status word has been written back
   task automatic frame(input int n, input logic [1:0] lb, input logic [4:0] f);
      int k;
      k = 0;
      for (int i = 0; i < n; i++) begin
         rx_valid <= 1'b1;
         rx_data <= $urandom;
         rx_last <= (i == n - 1);
         rx_last_bytes <= lb;
         rx_flags <= f;
         do tick(k); while (!rx_ready_r);
      end
      rx_valid <= 1'b0;
      while (q.size() != 0) tick(k);
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata);
      if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp});
      if (mem_req_r && mem_we_r && mem_ack && mem_addr_r < 32'h20) chk(mem_wdata_r);
   end
   initial begin
      int n, len;
      logic [1:0] lb;
      logic [4:0] f;
      logic ra;
      logic [31:0] st;
      void'($urandom(32'h5ed23b57));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      st = $urandom;
      axr(6'h08, 32'h00000001);
      axw(6'h3C, st, 2'h2);
      axw(6'h04, st, 2'h0);
      axr(6'h04, {st[31:2], 2'h0});
      @(posedge aclk);
      q.push_back(st);
      chk(tx_list_base);
      axr(6'h00, 32'h00000000);
      $display("test registers done");
      rxdl_mem_model_i.mem[1] = 32'h00008010;
      rxdl_mem_model_i.mem[2] = 32'h00000100;
      rxdl_mem_model_i.mem[3] = 32'h00000200;
      rxdl_mem_model_i.mem[5] = 32'h01000010;
      rxdl_mem_model_i.mem[6] = 32'h00000300;
      for (int i = 0; i < 6; i++) begin
         ra = i[0];
         n = 1 + $urandom % 4;
         lb = 2'($urandom);
         f = 5'($urandom);
         slow <= 1'($urandom);
         axw(6'h08, {1'b0, ra, 28'h0, 2'h3}, 2'h0);
         len = (n - 1) * 4 + (lb == 2'h0 ? 4 : lb);
         st = {1'b0, f[0] & ra, len[13:0], |f[4:1], 3'h0, f[1], 1'b0, 2'h3, 1'b0, f[2], 4'h0, |f[4:3], 1'b0};
         rxdl_mem_model_i.mem[cur * 4] = 32'h80000000;
         q.push_back(st);
         frame(n, lb, f);
         cur = 1 - cur;
      end
      $display("test frames done");
      rxdl_mem_model_i.mem[cur * 4] = 32'h80000000;
      rxdl_mem_model_i.mem[4 - cur * 4] = 32'h80000000;
      q.push_back(32'h00000200);
      q.push_back(32'h00240100);
      frame(9, 2'h0, 5'h00);
      rxdl_mem_model_i.mem[cur * 4] = 32'h80000000;
      q.push_back(32'h0000C300);
      frame(9, 2'h0, 5'h00);
      rxdl_mem_model_i.mem[4] = 32'h80000000;
      axw(6'h08, 32'h00000002, 2'h0);
      axr(6'h10, 32'h00000010);
      q.push_back(32'h0000C300);
      frame(5, 2'h0, 5'h00);
      $display("test spanning and truncation done");
      end_of_test;
   end
endmodule
`default_nettype wire

// ==== rxdl_mem_model.sv ====
/* host memory behind the engine's req/ack port.
   assumes word addresses below 1 KiB; the bench fills descriptors */
`timescale 1ns/1ps
`default_nettype none
module rxdl_mem_model (
   input wire logic aclk,
   input wire logic mem_req_r,
   input wire logic mem_we_r,
   input wire logic [31:0] mem_addr_r,
   input wire logic [31:0] mem_wdata_r,
   input wire logic slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] mem [0:255];
   logic [1:0] wait_r;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 32'h0;
   end
   // read data is only good in the ack cycle, so it flips otherwise
   always @(posedge aclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req_r && !mem_ack) begin
         if (slow && wait_r != 2'h3) wait_r <= wait_r + 2'h1;
         else begin
            wait_r <= 2'h0;
            mem_ack <= 1'b1;
            if (mem_we_r) mem[mem_addr_r[9:2]] <= mem_wdata_r;
            else mem_rdata <= mem[mem_addr_r[9:2]];
         end
      end
   end
endmodule
`default_nettype wire

// ==== rxdl_status.v ====
/*
  Builds the status word written back into a receive descriptor.
  Assumes all inputs are steady registers of the engine, same clock.
*/
`include "rxdl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module rxdl_status (
   input wire last_seg,
   input wire first_seg,
   input wire desc_err,
   input wire crc_err,
   input wire phy_err,
   input wire collision,
   input wire runt,
   input wire addr_fail,
   input wire rx_all,
   input wire [13:0] frame_len,
   output reg [31:0] status_word
);

   wire crc_any;
   assign crc_any = crc_err | phy_err;

   always @* begin
      status_word = 32'h00000000;
      // ownership is returned in the same word as all status
      status_word[`RXDL_ST_OWN] = 1'b0;
      status_word[`RXDL_ST_FF] = addr_fail & rx_all & last_seg;
      status_word[`RXDL_ST_FS] = first_seg;
      status_word[`RXDL_ST_LS] = last_seg;
      status_word[`RXDL_ST_DE] = desc_err & last_seg;
      if (last_seg) begin
         // frame-level fields only carry meaning in the closing descriptor
         if (!desc_err) begin
            status_word[`RXDL_ST_FL_HI:`RXDL_ST_FL_LO] = frame_len;
         end
         status_word[`RXDL_ST_CE] = crc_any;
         status_word[`RXDL_ST_CS] = collision;
         status_word[`RXDL_ST_RF] = runt;
         status_word[`RXDL_ST_ES] = crc_any | collision | runt | desc_err;
      end
   end

endmodule

`default_nettype wire
